// [design/tpd_defs.vh]
// Constants for the single pulse, DMA burst and debug hold timer block.
`ifndef TPD_DEFS_VH
`define TPD_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TPD_ADDR_W        8
`define TPD_OFF_CTRL      8'h00
`define TPD_OFF_COUNT     8'h04
`define TPD_OFF_RELOAD    8'h08
`define TPD_OFF_CMPVAL    8'h0C
`define TPD_OFF_DMA_CONFIG    8'h10
`define TPD_OFF_DMABUF    8'h14
`define TPD_OFF_STATUS    8'h18
`define TPD_OFF_MASK      8'h1C
`define TPD_OFF_OUTSTATE  8'h20

// ****************************************************************
// Control register fields
// ****************************************************************
`define TPD_CTRL_CEN      0
`define TPD_CTRL_SPM      1
`define TPD_CTRL_CFE      2
`define TPD_CTRL_OCC_LO   4
`define TPD_CTRL_OCC_HI   6
`define TPD_CTRL_TSEL_LO  8
`define TPD_CTRL_TSEL_HI  10
`define TPD_CTRL_ETP      12
`define TPD_CTRL_PSC_LO   13
`define TPD_CTRL_PSC_HI   14
`define TPD_CTRL_FLT_LO   16
`define TPD_CTRL_FLT_HI   19
`define TPD_CTRL_HOLD     20
`define TPD_CTRL_DMAEN    21
`define TPD_CTRL_EVMODE   22
`define TPD_CTRL_MASK     32'h007F7777

// ****************************************************************
// DMA config fields
// ****************************************************************
`define TPD_DMA_BASE_LO   0
`define TPD_DMA_BASE_HI   4
`define TPD_DMA_CNT_LO    8
`define TPD_DMA_CNT_HI    12

// ****************************************************************
// Status and mask bits
// ****************************************************************
`define TPD_ST_UPDATE     0
`define TPD_ST_MATCH      1
`define TPD_ST_TRIG       2
`define TPD_ST_DMADONE    3
`define TPD_ST_W          4

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define TPD_TSEL_EXT      3'h7
`define TPD_OCC_FROZEN    3'h0
`define TPD_OCC_SETMATCH  3'h1
`define TPD_OCC_CLRMATCH  3'h2
`define TPD_OCC_TOGGLE    3'h3
`define TPD_OCC_FORCELO   3'h4
`define TPD_OCC_FORCEHI   3'h5
`define TPD_OCC_PWMZERO   3'h6
`define TPD_OCC_PWMONE    3'h7
`define TPD_RST_RELOAD    32'h0000FFFF

`endif

// [design/tpd_timer.v]
// Timer core with single pulse, fast compare, event start, DMA burst, debug hold.

`include "tpd_defs.vh"

module tpd_timer #(
  parameter CNT_W = 16
) (
  // Clock, reset, clock enable
  input  wire                   mclk,
  input  wire                   srst,
  input  wire                   ce,
  // Register port
  input  wire [`TPD_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  // Trigger sources
  input  wire                   ext_trigger,
  input  wire                   int_trigger,
  // Debug halt from the core
  input  wire                   core_halted,
  // DMA request
  output reg                    dma_req,
  // Channel output and interrupt
  output reg                    prepared_output_reference,
  output wire                   irq
);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  reg [31:0]          ctrl_reg;
  reg [CNT_W-1:0]     count_reg;
  reg [CNT_W-1:0]     reload_reg;
  reg [CNT_W-1:0]     cmpval_reg;
  reg [4:0]           dma_base_select_reg;
  reg [4:0]           dma_transfer_count_reg;
  reg [`TPD_ST_W-1:0] status_reg;
  reg [`TPD_ST_W-1:0] mask_reg;

  wire       counter_enable      = ctrl_reg[`TPD_CTRL_CEN];
  wire       single_pulse_enable = ctrl_reg[`TPD_CTRL_SPM];
  wire       compare_fast_enable = ctrl_reg[`TPD_CTRL_CFE];
  wire [2:0] compare_output_control =
             ctrl_reg[`TPD_CTRL_OCC_HI:`TPD_CTRL_OCC_LO];
  wire [2:0] trigger_select = ctrl_reg[`TPD_CTRL_TSEL_HI:`TPD_CTRL_TSEL_LO];
  wire       external_trigger_polarity = ctrl_reg[`TPD_CTRL_ETP];
  wire [1:0] external_trigger_prescaler =
             ctrl_reg[`TPD_CTRL_PSC_HI:`TPD_CTRL_PSC_LO];
  wire [3:0] external_trigger_filter =
             ctrl_reg[`TPD_CTRL_FLT_HI:`TPD_CTRL_FLT_LO];
  wire       debug_hold  = ctrl_reg[`TPD_CTRL_HOLD];
  wire       dma_enable  = ctrl_reg[`TPD_CTRL_DMAEN];
  wire       event_mode  = ctrl_reg[`TPD_CTRL_EVMODE];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [1:0] etr_sync_reg;
  reg [1:0] halt_sync_reg;

  always @(posedge mclk) begin
    if (srst) begin
      etr_sync_reg  <= 2'h0;
      halt_sync_reg <= 2'h0;
    end else if (ce) begin
      etr_sync_reg  <= {etr_sync_reg[0], ext_trigger};
      halt_sync_reg <= {halt_sync_reg[0], core_halted};
    end
  end

  // ****************************************************************
  // External trigger conditioning
  // ****************************************************************
  // The filter needs the level to stay for filter+1 samples before it is
  // taken, so a setting of zero passes the synchronised level straight on.
  reg       etr_filt_reg;
  reg [3:0] flt_cnt_reg;
  reg       etr_prev_reg;
  reg [2:0] psc_cnt_reg;
  reg       etr_div_reg;
  reg       etr_div_prev_reg;

  wire etr_pol     = etr_sync_reg[1] ^ external_trigger_polarity;
  wire etr_rise    = etr_filt_reg & ~etr_prev_reg;
  wire [2:0] psc_top = (3'h1 << external_trigger_prescaler) - 3'h1;

  always @(posedge mclk) begin
    if (srst) begin
      etr_filt_reg     <= 1'b0;
      flt_cnt_reg      <= 4'h0;
      etr_prev_reg     <= 1'b0;
      psc_cnt_reg      <= 3'h0;
      etr_div_reg      <= 1'b0;
      etr_div_prev_reg <= 1'b0;
    end else if (ce) begin
      if (etr_pol == etr_filt_reg) begin
        flt_cnt_reg <= 4'h0;
      end else if (flt_cnt_reg >= external_trigger_filter) begin
        etr_filt_reg <= etr_pol;
        flt_cnt_reg  <= 4'h0;
      end else begin
        flt_cnt_reg <= flt_cnt_reg + 4'h1;
      end
      etr_prev_reg     <= etr_filt_reg;
      etr_div_prev_reg <= etr_div_reg;
      // Divided trigger: one output edge per 2^prescaler input edges.
      if (etr_rise) begin
        if (psc_cnt_reg >= psc_top) begin
          psc_cnt_reg <= 3'h0;
          etr_div_reg <= 1'b1;
        end else begin
          psc_cnt_reg <= psc_cnt_reg + 3'h1;
        end
      end else begin
        etr_div_reg <= 1'b0;
      end
    end
  end

  wire external_trigger_filtered = etr_div_reg & ~etr_div_prev_reg;

  reg  int_trig_prev_reg;
  always @(posedge mclk) begin
    if (srst) begin
      int_trig_prev_reg <= 1'b0;
    end else if (ce) begin
      int_trig_prev_reg <= int_trigger;
    end
  end

  // Trigger select 111 takes the filtered external trigger, else internal.
  wire trig_edge = (trigger_select == `TPD_TSEL_EXT) ?
                   external_trigger_filtered :
                   (int_trigger & ~int_trig_prev_reg);
  wire trig_start = trig_edge & (single_pulse_enable | event_mode);

  // ****************************************************************
  // Register write path, shared by software and the DMA burst buffer
  // ****************************************************************
  reg  [4:0] dma_idx_reg;
  reg        dma_busy_reg;

  wire       buf_wr = reg_wr & (reg_addr == `TPD_OFF_DMABUF);
  wire [4:0] dma_word = dma_base_select_reg + dma_idx_reg;
  wire [`TPD_ADDR_W-1:0] dma_addr = {1'b0, dma_word, 2'b00};
  // A buffer write lands on the register picked by base plus index.
  wire [`TPD_ADDR_W-1:0] wr_addr = buf_wr ? dma_addr : reg_addr;
  wire       wr_any = reg_wr & ~(buf_wr & (dma_addr == `TPD_OFF_DMABUF));

  function wr_hit;
    input [`TPD_ADDR_W-1:0] a;
    input [`TPD_ADDR_W-1:0] off;
    begin
      wr_hit = wr_any & (a == off);
    end
  endfunction

  wire wr_ctrl  = wr_hit(wr_addr, `TPD_OFF_CTRL);
  wire wr_count = wr_hit(wr_addr, `TPD_OFF_COUNT);

  // ****************************************************************
  // Counter and update event
  // ****************************************************************
  wire halted    = halt_sync_reg[1] & debug_hold;
  wire run       = counter_enable & ~halted;
  wire at_top    = (count_reg >= reload_reg);
  wire update_ev = run & at_top;
  wire match_ev  = run & (count_reg == cmpval_reg);

  reg fast_force_reg;

  always @(posedge mclk) begin
    if (srst) begin
      ctrl_reg  <= 32'h0000_0000;
      count_reg <= {CNT_W{1'b0}};
      fast_force_reg <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        // A software write to the enable either starts or stops a pulse;
        // stopping leaves the count where it stands.
        ctrl_reg <= reg_wdata & `TPD_CTRL_MASK;
      end else if (trig_start) begin
        ctrl_reg[`TPD_CTRL_CEN] <= 1'b1;
      end else if (update_ev & single_pulse_enable) begin
        ctrl_reg[`TPD_CTRL_CEN] <= 1'b0;
      end
      if (wr_count) begin
        count_reg <= reg_wdata[CNT_W-1:0];
      end else if (update_ev) begin
        count_reg <= {CNT_W{1'b0}};
      end else if (run) begin
        count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // Fast forcing holds from the trigger until the pulse ends.
      if (trig_start & single_pulse_enable & compare_fast_enable &
          compare_output_control[2] & compare_output_control[1]) begin
        fast_force_reg <= 1'b1;
      end else if (update_ev | ~counter_enable) begin
        fast_force_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Channel output reference
  // ****************************************************************
  reg oref_cmp_reg;
  reg oref_next;

  always @* begin
    oref_next = oref_cmp_reg;
    case (compare_output_control)
      `TPD_OCC_FROZEN:   oref_next = oref_cmp_reg;
      `TPD_OCC_SETMATCH: oref_next = match_ev ? 1'b1 : oref_cmp_reg;
      `TPD_OCC_CLRMATCH: oref_next = match_ev ? 1'b0 : oref_cmp_reg;
      `TPD_OCC_TOGGLE:   oref_next = oref_cmp_reg ^ match_ev;
      `TPD_OCC_FORCELO:  oref_next = 1'b0;
      `TPD_OCC_FORCEHI:  oref_next = 1'b1;
      `TPD_OCC_PWMZERO:  oref_next = (count_reg < cmpval_reg);
      `TPD_OCC_PWMONE:   oref_next = ~(count_reg < cmpval_reg);
      default:           oref_next = oref_cmp_reg;
    endcase
    // The match state of PWM zero is low and of PWM one is high.
    if (fast_force_reg) begin
      oref_next = compare_output_control[0];
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      oref_cmp_reg              <= 1'b0;
      prepared_output_reference <= 1'b0;
    end else if (ce) begin
      oref_cmp_reg              <= oref_next;
      prepared_output_reference <= oref_next;
    end
  end

  // ****************************************************************
  // DMA burst sequencing
  // ****************************************************************
  // An event arriving mid-burst restarts from the base; this keeps the
  // buffer always mapped to a well-defined register.
  always @(posedge mclk) begin
    if (srst) begin
      dma_req      <= 1'b0;
      dma_busy_reg <= 1'b0;
      dma_idx_reg  <= 5'h00;
    end else if (ce) begin
      if (update_ev & dma_enable) begin
        dma_busy_reg <= 1'b1;
        dma_idx_reg  <= 5'h00;
        dma_req      <= 1'b1;
      end else if (dma_busy_reg & buf_wr) begin
        dma_req <= 1'b0;
        if (dma_idx_reg >= dma_transfer_count_reg) begin
          dma_busy_reg <= 1'b0;
        end else begin
          dma_idx_reg <= dma_idx_reg + 5'h01;
        end
      end else if (dma_busy_reg & ~dma_req) begin
        dma_req <= 1'b1;
      end
    end
  end

  wire dma_done = dma_busy_reg & buf_wr &
                  (dma_idx_reg >= dma_transfer_count_reg);

  // ****************************************************************
  // Other registers, status and interrupt
  // ****************************************************************
  localparam [31:0] RST_RELOAD = `TPD_RST_RELOAD;
  wire [`TPD_ST_W-1:0] st_set = {dma_done, trig_edge, match_ev, update_ev};
  wire [`TPD_ST_W-1:0] st_clr =
       wr_hit(wr_addr, `TPD_OFF_STATUS) ? reg_wdata[`TPD_ST_W-1:0] :
       {`TPD_ST_W{1'b0}};

  always @(posedge mclk) begin
    if (srst) begin
      reload_reg             <= RST_RELOAD[CNT_W-1:0];
      cmpval_reg             <= {CNT_W{1'b0}};
      dma_base_select_reg    <= 5'h00;
      dma_transfer_count_reg <= 5'h00;
      status_reg             <= {`TPD_ST_W{1'b0}};
      mask_reg               <= {`TPD_ST_W{1'b0}};
    end else if (ce) begin
      if (wr_hit(wr_addr, `TPD_OFF_RELOAD)) begin
        reload_reg <= reg_wdata[CNT_W-1:0];
      end
      if (wr_hit(wr_addr, `TPD_OFF_CMPVAL)) begin
        cmpval_reg <= reg_wdata[CNT_W-1:0];
      end
      if (wr_hit(wr_addr, `TPD_OFF_DMA_CONFIG)) begin
        dma_base_select_reg <=
          reg_wdata[`TPD_DMA_BASE_HI:`TPD_DMA_BASE_LO];
        dma_transfer_count_reg <=
          reg_wdata[`TPD_DMA_CNT_HI:`TPD_DMA_CNT_LO];
      end
      if (wr_hit(wr_addr, `TPD_OFF_MASK)) begin
        mask_reg <= reg_wdata[`TPD_ST_W-1:0];
      end
      // A new event in the clearing cycle keeps its bit set.
      status_reg <= (status_reg & ~st_clr) | st_set;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    case (reg_addr)
      `TPD_OFF_CTRL:     rd_next = ctrl_reg;
      `TPD_OFF_COUNT:    rd_next[CNT_W-1:0] = count_reg;
      `TPD_OFF_RELOAD:   rd_next[CNT_W-1:0] = reload_reg;
      `TPD_OFF_CMPVAL:   rd_next[CNT_W-1:0] = cmpval_reg;
      `TPD_OFF_DMA_CONFIG: begin
        rd_next[`TPD_DMA_BASE_HI:`TPD_DMA_BASE_LO] = dma_base_select_reg;
        rd_next[`TPD_DMA_CNT_HI:`TPD_DMA_CNT_LO]   = dma_transfer_count_reg;
      end
      `TPD_OFF_STATUS:   rd_next[`TPD_ST_W-1:0] = status_reg;
      `TPD_OFF_MASK:     rd_next[`TPD_ST_W-1:0] = mask_reg;
      `TPD_OFF_OUTSTATE: rd_next[2:0] = {dma_busy_reg, halted,
                                         prepared_output_reference};
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_next : 32'h0000_0000;
    end
  end

endmodule

// [test/tpd_dma_model.sv]
// Behavioural DMA controller that answers the timer's burst requests.
module tpd_dma_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Request from the timer and answer delay in cycles
  input  wire logic        dma_req,
  input  wire logic [3:0]  lat,
  // Buffer write towards the timer
  output logic             dma_wr,
  output logic [31:0]      dma_wdata,
  output logic [7:0]       n_wr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    dma_wr = 1'b0;
    dma_wdata = 32'h00000000;
    n_wr = 8'h00;
    forever begin
      @(posedge mclk);
      if (dma_req && !srst) begin
        repeat (lat) @(posedge mclk);
        dma_wr <= 1'b1;
        dma_wdata <= 32'h00000100 + n_wr;
        @(posedge mclk);
        dma_wr <= 1'b0;
        dma_wdata <= ~dma_wdata;
        n_wr <= n_wr + 8'h01;
        // The request must fall before the next one is taken.
        while (dma_req) @(posedge mclk);
      end
    end
  end
endmodule

// [test/tpd_timer_assertions.sv]
// Port-level checks for the pulse, DMA and debug-hold timer.
`include "tpd_defs.vh"

module tpd_timer_assertions #(
  parameter CNT_W = 16
) (
  // Clock, reset and clock enable
  input wire                   mclk,
  input wire                   srst,
  input wire                   ce,
  // Register port
  input wire [`TPD_ADDR_W-1:0] reg_addr,
  input wire [31:0]            reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [31:0]            reg_rdata,
  // Triggers, halt and outputs
  input wire                   ext_trigger,
  input wire                   int_trigger,
  input wire                   core_halted,
  input wire                   dma_req,
  input wire                   prepared_output_reference,
  input wire                   irq
);
  timeunit 1ns;
  timeprecision 100ps;

  wire rd_ok = reg_rd && ce;
  wire buf_wr = reg_wr && ce && reg_addr == `TPD_OFF_DMABUF;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  rst_quiet_a: assert property (disable iff (1'b0)
    $past(srst) && $past(ce) |-> !dma_req && !irq
    && !prepared_output_reference && reg_rdata == 32'h0)
    else $error("outputs not quiet after reset");
  rdata_idle_a: assert property ($past(ce) && !$past(reg_rd)
    |-> reg_rdata == 32'h0) else $error("read data not idle");
  dma_drop_a: assert property (dma_req && buf_wr |=> !dma_req)
    else $error("request stayed after buffer write");
  dma_hold_a: assert property (dma_req && ce && !buf_wr
    |=> dma_req) else $error("request fell before buffer write");
  buf_read_a: assert property (rd_ok
    && reg_addr == `TPD_OFF_DMABUF |=> reg_rdata == 32'h0)
    else $error("buffer read not zero");
  unmapped_a: assert property (rd_ok
    && reg_addr > `TPD_OFF_OUTSTATE |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_w_a: assert property (rd_ok && reg_addr == `TPD_OFF_STATUS
    |=> reg_rdata[31:4] == 28'h0) else $error("status upper bits set");
  mask_off_a: assert property (reg_wr && ce
    && reg_addr == `TPD_OFF_MASK && reg_wdata[3:0] == 4'h0
    |=> !irq) else $error("irq with empty mask");
  oref_rb_a: assert property (rd_ok && reg_addr == `TPD_OFF_OUTSTATE
    |=> reg_rdata[0] == $past(prepared_output_reference))
    else $error("reference readback wrong");
  ctrl_rb_a: assert property (reg_wr && ce
    && reg_addr == `TPD_OFF_CTRL ##2 rd_ok
    && reg_addr == `TPD_OFF_CTRL |=> ((reg_rdata ^ ($past(reg_wdata, 3)
    & `TPD_CTRL_MASK)) & ~32'h1) == 32'h0)
    else $error("control readback wrong");
endmodule

bind tpd_timer tpd_timer_assertions #(.CNT_W(CNT_W)) i_chk (
  .mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_trigger(ext_trigger),
  .int_trigger(int_trigger), .core_halted(core_halted),
  .dma_req(dma_req), .irq(irq),
  .prepared_output_reference(prepared_output_reference)
);

// [test/tpd_timer_test.sv]
// Self-checking bench for the pulse, DMA and debug-hold timer.
`include "tpd_defs.vh"

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tpd_timer_test;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } tpd_row_t;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  tb_addr = 8'h00;
  logic [31:0] tb_wdata = 32'h00000000;
  logic        tb_wr = 1'b0;
  logic        tb_rd = 1'b0;
  logic        ext_trigger = 1'b0;
  logic        int_trigger = 1'b0;
  logic        core_halted = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [31:0] reg_rdata;
  logic [31:0] dma_wdata;
  logic [31:0] rv;
  logic [31:0] v1;
  logic [7:0]  n_wr;
  logic        dma_wr;
  logic        dma_req;
  logic        oref;
  logic        irq;
  int          n_fail = 0;
  int          cmp_count = 0;
  tpd_row_t    rows [8] = '{
    '{1'b1, 8'h04, 32'h00001234, 32'h00001234},
    '{1'b1, 8'h08, 32'h00000055, 32'h00000055},
    '{1'b1, 8'h0C, 32'h000000AA, 32'h000000AA},
    '{1'b1, 8'h10, 32'h00000302, 32'h00000302},
    '{1'b1, 8'h1C, 32'h0000000F, 32'h0000000F},
    '{1'b1, 8'h00, 32'hFFFFFFFE, 32'hFFFFFFFE & `TPD_CTRL_MASK},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h00000000},
    '{1'b0, 8'h14, 32'h00000000, 32'h00000000}};

  // The DMA model borrows the register port only while it writes.
  wire         reg_wr = tb_wr | dma_wr;
  wire [7:0]   reg_addr = dma_wr ? `TPD_OFF_DMABUF : tb_addr;
  wire [31:0]  reg_wdata = dma_wr ? dma_wdata : tb_wdata;

  tpd_timer i_dut (
    .mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(tb_rd),
    .reg_rdata(reg_rdata), .ext_trigger(ext_trigger),
    .int_trigger(int_trigger), .core_halted(core_halted),
    .dma_req(dma_req), .prepared_output_reference(oref), .irq(irq)
  );

  tpd_dma_model i_dma (
    .mclk(mclk), .srst(srst), .dma_req(dma_req), .lat(lat),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .n_wr(n_wr)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tb_addr <= a;
    tb_wdata <= d;
    tb_wr <= 1'b1;
    @(posedge mclk);
    tb_wr <= 1'b0;
    // The idle edge keeps a following write from raising the strobe in
    // the same step that lowered it.
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a);
    tb_addr <= a;
    tb_rd <= 1'b1;
    @(posedge mclk);
    tb_rd <= 1'b0;
    @(posedge mclk);
    rv = reg_rdata;
  endtask

  task automatic do_reset;
    srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_dma(input logic [7:0] n);
    for (int i = 0; i < 400 && n_wr < n; i++)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (6000) @(posedge mclk);
    n_fail++;
    close_out;
  end

  initial begin
    do_reset;
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK(rv, rows[i].e)
    end
    $display("done: register table");
    do_reset;
    rd(8'h08);
    `CHK(rv, `TPD_RST_RELOAD)
    rd(8'h00);
    `CHK(rv, 32'h00000000)
    `CHK(irq, 1'b0)
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, {25'h0, k[2:0], 4'h0});
      rd(8'h00);
      `CHK(rv[6:4], k[2:0])
      if (k == 4 || k == 5)
        `CHK(oref, k[0])
    end
    $display("done: reset and output modes");
    wr(8'h08, 32'h00000005);
    wr(8'h00, 32'h00000003);
    rd(8'h00);
    `CHK(rv[0], 1'b1)
    repeat (20) @(posedge mclk);
    rd(8'h00);
    `CHK(rv[0], 1'b0)
    rd(8'h04);
    `CHK(rv, 32'h00000000)
    wr(8'h08, 32'h0000FFFF);
    wr(8'h04, 32'h00000010);
    wr(8'h00, 32'h00000001);
    repeat (8) @(posedge mclk);
    wr(8'h00, 32'h00000000);
    rd(8'h04);
    v1 = rv;
    repeat (5) @(posedge mclk);
    rd(8'h04);
    `CHK(rv, v1)
    `CHK(v1 > 32'h00000010, 1'b1)
    $display("done: software pulse and stop");
    wr(8'h04, 32'h00000000);
    wr(8'h0C, 32'h00000020);
    wr(8'h08, 32'h00000040);
    wr(8'h00, 32'h00000076);
    int_trigger <= 1'b1;
    @(posedge mclk);
    int_trigger <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(oref, 1'b1)
    rd(8'h20);
    `CHK(rv[0], 1'b1)
    rd(8'h00);
    `CHK(rv[0], 1'b1)
    do_reset;
    wr(8'h0C, 32'h00000020);
    wr(8'h08, 32'h00000040);
    wr(8'h00, 32'h00000036);
    int_trigger <= 1'b1;
    @(posedge mclk);
    int_trigger <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(oref, 1'b0)
    $display("done: trigger start and fast compare");
    wr(8'h04, 32'h00000000);
    wr(8'h00, 32'h00402700);
    rd(8'h00);
    `CHK(rv[0], 1'b0)
    // Divide by two: only the second rising edge may start the counter.
    for (int p = 0; p < 2; p++) begin
      ext_trigger <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_trigger <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(8'h00);
      `CHK(rv[0], p[0])
    end
    repeat (6) @(posedge mclk);
    rd(8'h00);
    `CHK(rv[0], 1'b1)
    wr(8'h00, 32'h00100001);
    core_halted <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(8'h04);
    v1 = rv;
    repeat (6) @(posedge mclk);
    rd(8'h04);
    `CHK(rv, v1)
    rd(8'h20);
    `CHK(rv[1], 1'b1)
    core_halted <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(8'h04);
    `CHK(rv != v1, 1'b1)
    // Clock enable low must freeze the running counter.
    wr(8'h04, 32'h00000000);
    rd(8'h04);
    v1 = rv;
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    rd(8'h04);
    `CHK(rv, v1 + 32'h00000002)
    $display("done: event start and debug hold");
    wr(8'h00, 32'h00000000);
    wr(8'h04, 32'h00000000);
    wr(8'h18, 32'h0000000F);
    wr(8'h1C, 32'h00000008);
    wr(8'h10, 32'h00000102);
    wr(8'h08, 32'h00000004);
    wr(8'h00, 32'h00200003);
    wait_dma(8'h02);
    `CHK(n_wr, 8'h02)
    `CHK(dma_req, 1'b0)
    `CHK(irq, 1'b1)
    rd(8'h08);
    `CHK(rv, 32'h00000100)
    rd(8'h18);
    `CHK(rv, 32'h00000009)
    rd(8'h0C);
    `CHK(rv, 32'h00000101)
    lat <= 4'h3;
    wr(8'h08, 32'h00000004);
    wr(8'h00, 32'h00200003);
    wait_dma(8'h04);
    `CHK(n_wr, 8'h04)
    rd(8'h08);
    `CHK(rv, 32'h00000102)
    rd(8'h0C);
    `CHK(rv, 32'h00000103)
    wr(8'h1C, 32'h00000000);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(8'h1C, 32'h00000008);
    @(posedge mclk);
    `CHK(irq, 1'b1)
    wr(8'h18, 32'h00000008);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    $display("done: DMA bursts and interrupt");
    close_out;
  end
endmodule
